// File: pc_paging_pkg.sv
// constants shared by the program counter and paging block
package pc_paging_pkg;
  localparam int          PC_W          = 12;
  localparam int          LOW_W         = 10;
  localparam int          DATA_W        = 8;
  localparam int          PAGE_W        = 2;
  localparam int          PTR_W         = 6;
  localparam int          BANK_W        = 2;
  localparam int          ROM_WORD_W    = 13;
  localparam int          STACK_DEPTH   = 8;
  localparam int          STACK_PTR_W   = 3;
  localparam logic [7:0]  ADDR_INDIRECT = 8'h00;
  localparam logic [7:0]  ADDR_PC       = 8'h02;
  localparam logic [7:0]  ADDR_RAMSEL   = 8'h04;
  localparam logic [11:0] PC_RESET      = 12'h000;
  localparam logic [7:0]  RAMSEL_RESET  = 8'h00;
  localparam logic [7:0]  READ_ZERO     = 8'h00;
  localparam int          MOV_KEEP_LSB  = 8;
  localparam int          PAGE_LSB      = 10;
  localparam int          BANK_LSB      = 6;
endpackage

// File: return_stack.sv
// circular return-address stack
`timescale 1ns/10ps
`default_nettype none
module return_stack
  import pc_paging_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              clkEn,
  input  wire logic              push,
  input  wire logic              pop,
  input  wire logic [PC_W-1:0]   pushData,
  output logic      [PC_W-1:0]   topData
);
  logic [PC_W-1:0]        stackMem [STACK_DEPTH];
  logic [STACK_PTR_W-1:0] sp_r;

  // pointer wraps on overflow and underflow
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sp_r <= '0;
    end else if (clkEn) begin
      if (push) begin
        sp_r <= sp_r + 3'h1;
      end else if (pop) begin
        sp_r <= sp_r - 3'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clkEn && push) begin
      stackMem[sp_r] <= pushData;
    end
  end

  assign topData = stackMem[sp_r - 3'h1];
endmodule
`default_nettype wire

// File: program_counter_paging.sv
// program counter, page loading and indirect data access of the core
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - reset clears every program counter bit so execution restarts at address zero.
// - the counter is twelve bits wide and addresses a 4K by 13-bit instruction ROM.
// - a jump loads its 10-bit immediate target into the low counter bits.
// - a call loads its target like a jump and pushes the next instruction address.
// - every kind of return loads the counter from the top of the return stack.
// - adding the accumulator to the counter register adds it as an offset to the next address, with carry through bit 9 only.
// - moving the accumulator into the counter register replaces the low 8 bits and keeps bits 8 and 9.
// - jump and call load counter bits 10 and 11 from the page select bits.
// - register address zero holds nothing and reaches the location chosen by the RAM select pointer.
// - the pointer's low six bits pick one of 64 registers and its top two bits pick one of four banks.
// - the page select bits, as ROM pages 0 to 3, go into the top counter bits on a jump, call, add or move into the counter.
// - returns never touch the page select bits, so they resume on the calling page.
module program_counter_paging
  import pc_paging_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic                clkEn,
  input  wire logic                opStep,
  input  wire logic                opJump,
  input  wire logic                opCall,
  input  wire logic                opReturn,
  input  wire logic                opAddPc,
  input  wire logic [LOW_W-1:0]    jumpTarget,
  input  wire logic [DATA_W-1:0]   accum,
  input  wire logic [PAGE_W-1:0]   pageSelectBits,
  input  wire logic [7:0]          regAddr,
  input  wire logic [DATA_W-1:0]   regWrData,
  input  wire logic                regWr,
  input  wire logic                regRd,
  output logic      [DATA_W-1:0]   regRdData,
  output logic      [PC_W-1:0]     romAddr,
  output logic      [DATA_W-1:0]   ramSelectPointer
);
  localparam int NUM_BANKS = 2**BANK_W;
  localparam int BANK_REGS = 2**PTR_W;

  // where the next counter value comes from, one bit per source
  typedef enum logic [5:0] {
    SRC_HOLD   = 6'b000001,
    SRC_BRANCH = 6'b000010,
    SRC_RETURN = 6'b000100,
    SRC_ADD    = 6'b001000,
    SRC_MOVE   = 6'b010000,
    SRC_STEP   = 6'b100000
  } pc_src_e;

  // where the read data comes from, one bit per source
  typedef enum logic [3:0] {
    RD_NONE    = 4'b0001,
    RD_WINDOW  = 4'b0010,
    RD_COUNTER = 4'b0100,
    RD_POINTER = 4'b1000
  } rd_src_e;

  // counter
  logic [PAGE_W-1:0]    pcPage_r;
  logic [LOW_W-1:0]     pcLow_r;
  logic [PC_W-1:0]      pc_r;
  logic [PC_W-1:0]      pc_nxt;
  logic [PC_W-1:0]      pcPlusOne;
  logic [LOW_W-1:0]     addSum;
  logic [PC_W-1:0]      branchPc;
  logic [PC_W-1:0]      addPc;
  logic [PC_W-1:0]      movePc;
  logic                 branchOp;
  pc_src_e              pcSrc;

  // return stack
  logic [PC_W-1:0]      stackTop;
  logic                 pushReq;
  logic                 popReq;

  // ram select pointer and data banks
  logic [BANK_W-1:0]    bankSel_r;
  logic [PTR_W-1:0]     regSel_r;
  logic [DATA_W-1:0]    ramSel_r;
  logic [DATA_W-1:0]    ramSel_nxt;
  logic [NUM_BANKS-1:0] bankWe;
  logic [DATA_W-1:0]    bankRd [NUM_BANKS];
  logic [DATA_W-1:0]    windowData;

  // register bus
  logic                 wrIndirect;
  logic                 wrPc;
  logic                 wrRamSel;
  logic                 rdIndirect;
  logic                 rdPc;
  logic                 rdRamSel;
  rd_src_e              rdSrc;
  logic [DATA_W-1:0]    rdData_r;
  logic [DATA_W-1:0]    rdData_nxt;

  function automatic logic hits(input logic [7:0] a, input logic [7:0] target);
    return a == target;
  endfunction

  function automatic logic isIndirect(input logic [7:0] a);
    return hits(a, ADDR_INDIRECT);
  endfunction

  function automatic logic isCounter(input logic [7:0] a);
    return hits(a, ADDR_PC);
  endfunction

  function automatic logic isPointer(input logic [7:0] a);
    return hits(a, ADDR_RAMSEL);
  endfunction

  // joins the page select bits above a 10-bit in-page address
  function automatic logic [PC_W-1:0] onPage(input logic [PAGE_W-1:0] page, input logic [LOW_W-1:0] low);
    return {page, low};
  endfunction

  function automatic logic [BANK_W-1:0] bankOf(input logic [DATA_W-1:0] ptr);
    return ptr[DATA_W-1:BANK_LSB];
  endfunction

  function automatic logic [PTR_W-1:0] regOf(input logic [DATA_W-1:0] ptr);
    return ptr[PTR_W-1:0];
  endfunction

  // register bus decode
  assign wrIndirect = clkEn && regWr && isIndirect(regAddr);
  assign wrPc       = clkEn && regWr && isCounter(regAddr);
  assign wrRamSel   = clkEn && regWr && isPointer(regAddr);
  assign rdIndirect = regRd && isIndirect(regAddr);
  assign rdPc       = regRd && isCounter(regAddr);
  assign rdRamSel   = regRd && isPointer(regAddr);

  // candidate counter values
  assign pcPlusOne = pc_r + 12'h001;
  assign addSum    = pcPlusOne[LOW_W-1:0] + {2'h0, accum};
  assign branchOp  = opJump || opCall;
  assign branchPc  = onPage(pageSelectBits, jumpTarget);
  assign addPc     = onPage(pageSelectBits, addSum);
  assign movePc    = onPage(pageSelectBits, {pc_r[PAGE_LSB-1:MOV_KEEP_LSB], regWrData});

  // source select, by priority of the instruction in flight
  always_comb begin
    pcSrc = SRC_HOLD;
    if (branchOp) begin
      pcSrc = SRC_BRANCH;
    end else if (opReturn) begin
      pcSrc = SRC_RETURN;
    end else if (opAddPc) begin
      pcSrc = SRC_ADD;
    end else if (wrPc) begin
      pcSrc = SRC_MOVE;
    end else if (opStep) begin
      pcSrc = SRC_STEP;
    end
  end

  // next counter value
  always_comb begin
    pc_nxt = pc_r;
    unique case (pcSrc)
      SRC_HOLD: begin
        pc_nxt = pc_r;
      end
      SRC_BRANCH: begin
        pc_nxt = branchPc;
      end
      SRC_RETURN: begin
        pc_nxt = stackTop;
      end
      SRC_ADD: begin
        pc_nxt = addPc;
      end
      SRC_MOVE: begin
        pc_nxt = movePc;
      end
      SRC_STEP: begin
        pc_nxt = pcPlusOne;
      end
    endcase
  end

  // page half of the counter
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pcPage_r <= PC_RESET[PC_W-1:PAGE_LSB];
    end else if (clkEn) begin
      pcPage_r <= pc_nxt[PC_W-1:PAGE_LSB];
    end
  end

  // in-page half of the counter
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pcLow_r <= PC_RESET[PAGE_LSB-1:0];
    end else if (clkEn) begin
      pcLow_r <= pc_nxt[PAGE_LSB-1:0];
    end
  end

  assign pc_r = {pcPage_r, pcLow_r};

  // call pushes, return pops unless a call wins the same cycle
  assign pushReq = opCall;
  assign popReq  = opReturn && !opCall;

  return_stack return_stack_i (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .push     (pushReq),
    .pop      (popReq),
    .pushData (pcPlusOne),
    .topData  (stackTop)
  );

  // pointer register, kept as bank and register fields
  assign ramSel_nxt = wrRamSel ? regWrData : ramSel_r;
  assign ramSel_r   = {bankSel_r, regSel_r};

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bankSel_r <= RAMSEL_RESET[DATA_W-1:BANK_LSB];
    end else if (clkEn) begin
      bankSel_r <= bankOf(ramSel_nxt);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      regSel_r <= RAMSEL_RESET[PTR_W-1:0];
    end else if (clkEn) begin
      regSel_r <= regOf(ramSel_nxt);
    end
  end

  // address zero is a window onto the selected bank and register
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    logic [DATA_W-1:0] bankMem [BANK_REGS];

    assign bankWe[b] = wrIndirect && (bankSel_r == BANK_W'(b));

    always_ff @(posedge sys_clk) begin
      if (bankWe[b]) begin
        bankMem[regSel_r] <= regWrData;
      end
    end

    assign bankRd[b] = bankMem[regSel_r];
  end

  assign windowData = bankRd[bankSel_r];

  // read source select
  always_comb begin
    rdSrc = RD_NONE;
    if (rdIndirect) begin
      rdSrc = RD_WINDOW;
    end else if (rdPc) begin
      rdSrc = RD_COUNTER;
    end else if (rdRamSel) begin
      rdSrc = RD_POINTER;
    end
  end

  // read data for the cycle after the strobe
  always_comb begin
    rdData_nxt = READ_ZERO;
    unique case (rdSrc)
      RD_NONE: begin
        rdData_nxt = READ_ZERO;
      end
      RD_WINDOW: begin
        rdData_nxt = windowData;
      end
      RD_COUNTER: begin
        rdData_nxt = pc_r[DATA_W-1:0];
      end
      RD_POINTER: begin
        rdData_nxt = ramSel_r;
      end
    endcase
  end

  // read data register, held while the clock enable is low
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdData_r <= READ_ZERO;
    end else if (clkEn) begin
      rdData_r <= rdData_nxt;
    end
  end

  // outputs straight from registers
  assign regRdData        = rdData_r;
  assign romAddr          = {pcPage_r, pcLow_r};
  assign ramSelectPointer = {bankSel_r, regSel_r};
endmodule
`default_nettype wire

// File: pcp_decoder_model.sv
// decoder model turning an opcode into one-hot instruction strobes
`timescale 1ns/10ps
`default_nettype none
module pcp_decoder_model (
  input  wire logic [2:0] code,
  output logic            step,
  output logic            jump,
  output logic            call,
  output logic            ret,
  output logic            add
);
  // codes 5 to 7 decode to no instruction
  assign {add, ret, call, jump, step} = 5'h01 << code;
endmodule
`default_nettype wire

// File: pcp_checker.sv
// assertion checker for the program counter block
`timescale 1ns/10ps
`default_nettype none
module pcp_checker
  import pc_paging_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic              clkEn,
  input wire logic              opStep,
  input wire logic              opJump,
  input wire logic              opCall,
  input wire logic              opReturn,
  input wire logic              opAddPc,
  input wire logic              regWr,
  input wire logic              regRd,
  input wire logic [LOW_W-1:0]  jumpTarget,
  input wire logic [DATA_W-1:0] accum,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic [DATA_W-1:0] regRdData,
  input wire logic [DATA_W-1:0] ramSelectPointer,
  input wire logic [PAGE_W-1:0] pageSelectBits,
  input wire logic [7:0]        regAddr,
  input wire logic [PC_W-1:0]   romAddr
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire logic go = clkEn && !opJump && !opCall;
  sequence callRet; clkEn && opCall ##1 go && opReturn; endsequence
  sequence winWrRd; clkEn && regWr && regAddr == ADDR_INDIRECT ##1 clkEn && regRd && regAddr == ADDR_INDIRECT; endsequence
  a_reset_clears_pc: assert property (disable iff (1'b0) !rst_n && clkEn |=> romAddr == PC_RESET)
    else $error("pc not cleared");
  a_jump_page_load: assert property (clkEn && (opJump || opCall) |=>
    romAddr == {$past(pageSelectBits), $past(jumpTarget)}) else $error("bad jump");
  a_return_call_site: assert property (callRet |=> romAddr == $past(romAddr, 2) + 12'h001)
    else $error("bad return");
  a_add_offset: assert property (go && !opReturn && opAddPc |=>
    romAddr == {$past(pageSelectBits), 10'($past(romAddr) + $past(accum) + 12'h001)}) else $error("bad add");
  a_move_low_bits: assert property (go && !opReturn && !opAddPc && regWr && regAddr == ADDR_PC |=>
    romAddr[7:0] == $past(regWrData) && $stable(romAddr[9:8])) else $error("bad move");
  a_ptr_write: assert property (clkEn && regWr && regAddr == ADDR_RAMSEL |=>
    ramSelectPointer == $past(regWrData)) else $error("bad pointer");
  a_window_rw: assert property (winWrRd |=> regRdData == $past(regWrData, 2))
    else $error("bad window");
  a_rd_idle_zero: assert property (clkEn && !regRd |=> regRdData == READ_ZERO) else $error("read data not zero");
endmodule
bind program_counter_paging pcp_checker pcp_checker_i (.*);
`default_nettype wire

// File: program_counter_paging_tb_top.sv
// self-checking bench for the program counter block
`timescale 1ns/10ps
`default_nettype none
module program_counter_paging_tb_top import pc_paging_pkg::*;;
  logic        sys_clk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0, en = 1'b1, st, jp, cl, rt, ad;
  logic [2:0]  code = 3'h7;
  logic [9:0]  tgt = '0;
  logic [7:0]  acc = '0, regAddr = '0, wd = '0, rd, ptr;
  logic [1:0]  pg = '0;
  logic [11:0] pc, ret, old;
  logic [16:0] r = 17'h10315;
  int          fail_count = 0, checked = 0, cyc = 0;
  pcp_decoder_model pcp_decoder_model_i (.code(code), .step(st), .jump(jp), .call(cl), .ret(rt), .add(ad));
  program_counter_paging program_counter_paging_i (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(en), .opStep(st),
    .opJump(jp), .opCall(cl), .opReturn(rt), .opAddPc(ad), .jumpTarget(tgt), .accum(acc), .pageSelectBits(pg),
    .regAddr(regAddr), .regWrData(wd), .regWr(regWr), .regRd(regRd), .regRdData(rd), .romAddr(pc),
    .ramSelectPointer(ptr));
  initial forever #2 sys_clk = ~sys_clk;
  function automatic logic [16:0] lfsr(input logic [16:0] v); return {v[15:0], v[16] ^ v[13]}; endfunction
  function automatic logic [11:0] addx(input logic [11:0] p, input logic [1:0] g, input logic [7:0] a);
    return {g, 10'(p + a + 12'h001)};
  endfunction
  task chk(input logic [11:0] s, e);
    checked++;
    if (s !== e) begin fail_count++; $display("mismatch %0t value %h", $time, s); end
  endtask
  task op(input logic [2:0] c);
    r = lfsr(r);
    code <= c; tgt <= r[9:0]; acc <= r[16:9]; pg <= r[11:10];
    @(posedge sys_clk); code <= 3'h7; #1;
  endtask
  task bus(input logic w, input logic [7:0] a, d);
    regWr <= w; regRd <= !w; regAddr <= a; wd <= d;
    @(posedge sys_clk); regWr <= 1'b0; regRd <= 1'b0; #1;
  endtask
  task complete_run;
    $display("fail_count %0d checked %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk) if (++cyc == 2000) begin fail_count++; complete_run(); end
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1 chk(pc, PC_RESET);
    repeat (30) begin
      op(3'h1); chk(pc, {pg, tgt}); ret = pc + 12'h001;
      op(3'h2); chk(pc, {pg, tgt}); old = pc;
      op(3'h4); chk(pc, addx(old, pg, acc));
      op(3'h3); chk(pc, ret);
      old = pc; op(3'h0); chk(pc, old + 12'h001);
      old = pc; op(3'h2); op(3'h3); chk(pc, old + 12'h001);
    end
    old = pc; en <= 1'b0; op(3'h1); chk(pc, old); en <= 1'b1;
    bus(1'b1, ADDR_RAMSEL, r[7:0]); chk(ptr, r[7:0]);
    bus(1'b1, ADDR_INDIRECT, 8'h5a); bus(1'b0, ADDR_INDIRECT, 8'h00); chk(rd, 8'h5a);
    bus(1'b1, ADDR_RAMSEL, r[7:0] ^ 8'h40); bus(1'b1, ADDR_INDIRECT, 8'ha5);
    bus(1'b1, ADDR_RAMSEL, r[7:0]); bus(1'b0, ADDR_INDIRECT, 8'h00); chk(rd, 8'h5a);
    old = pc; bus(1'b1, ADDR_PC, 8'hc3); chk(pc[9:0], {old[9:8], 8'hc3});
    bus(1'b0, ADDR_PC, 8'h00); chk(rd, 8'hc3);
    bus(1'b0, 8'h0b, 8'h00); chk(rd, READ_ZERO);
    complete_run();
  end
endmodule
`default_nettype wire
